// ---- core/bis_consts.vh ----
// Constants for the burner ignition sequencer
`ifndef BIS_CONSTS_VH
`define BIS_CONSTS_VH
`define BIS_CLK_HZ 10000000
`define BIS_TICK_PER_SEC 10
`define BIS_INIT_SEC 10
`define BIS_ANN_SEC 5
`define BIS_TRANS_SEC 2
`define BIS_LF_GRACE_SEC 2
`define BIS_TRIAL_SEC 4
`define BIS_P2_SEC 5
`define BIS_STEP_SEC 2
`define BIS_DEB_SEC 3
`define BIS_ALARM_MIN 4
`define BIS_LOCK_MIN 8
`define BIS_SEC_PER_MIN 60
`define BIS_MOTOR_LOW 2'h0
`define BIS_MOTOR_MOD 2'h2
`define BIS_SEQ_NORMAL 2'h0
`define BIS_SEQ_HILO 2'h1
`define BIS_SEQ_OFFON 2'h2
`endif

// ---- core/bis_timer.v ----
// Seconds counter with synchronous clear
`timescale 1ns/10ps
module bis_timer #(
  parameter WIDTH = 10
) (
  clk_sys,
  rst_n,
  secTick,
  clear,
  count
);
  input wire clk_sys;
  input wire rst_n;
  input wire secTick;
  input wire clear;
  output reg [WIDTH-1:0] count;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      count <= {WIDTH{1'b0}};
    else if (clear)
      count <= {WIDTH{1'b0}};
    else if (secTick && count != {WIDTH{1'b1}})
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
  end
endmodule // bis_timer

// ---- core/bis_sequencer.v ----
// Burner ignition sequencer state machine
`timescale 1ns/10ps
`include "bis_consts.vh"
// How it works
// - Initiate ten seconds, then standby if fault-free
// - Line fault holds initiate; ten seconds after clearing
// - Fault annunciation held at least five seconds
// - Function one starts jumpered sequence; holds block
// - Normal one needs limits, low fire, function one
// - Normal one: igniter pilot on, low fire
// - Low-fire loss after two seconds locks out
// - Limits loss in normal one locks out
// - Four seconds: igniter off, flame check, function two
// - Normal two five seconds, flame and low-fire checked
// - After timer: back, hold or part three
// - Part three lockouts: limits, flame, two low four high
// - Modulate or low fire with four-minute alarm
// - Both low: alarm four, lock eight, debounce return
// - Part three ends to standby on function one
// - High/low one entry and outputs
// - High/low one four seconds then flame check
// - High/low two pilot low fire, two-second timer
// - High state modulate, returns or standby
// - Off/on one four seconds, modulate, limits checked
// - Off/on two main on, flame and limits checked
// - Required input missing during step locks out
module bis_sequencer #(
  parameter TICK_DIV = `BIS_CLK_HZ / `BIS_TICK_PER_SEC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire lineFault,
  input wire [1:0] seqSelect,
  input wire holdActive,
  input wire limitsOk,
  input wire lowFireSw,
  input wire flameSensed,
  input wire sf1,
  input wire sf2,
  input wire sf3,
  input wire sf4,
  input wire lockoutReset,
  output reg igniterOn,
  output reg pilotOn,
  output reg mainOn,
  output reg airOn,
  output reg flameProven,
  output reg alarmOn,
  output reg [1:0] motorPos,
  output reg faultAnnounce,
  output reg [11:0] stateCode
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam S_INIT = 12'h001;
  localparam S_STBY = 12'h002;
  localparam S_TRAN = 12'h004;
  localparam S_N1 = 12'h008;
  localparam S_N1END = 12'h010;
  localparam S_N2 = 12'h020;
  localparam S_N3 = 12'h040;
  localparam S_H1 = 12'h080;
  localparam S_H2 = 12'h100;
  localparam S_HIGH = 12'h200;
  localparam S_O1 = 12'h400;
  localparam S_O2 = 12'h800;
  localparam S_LOCK = 12'h000;

  localparam [9:0] T_INIT = `BIS_INIT_SEC;
  localparam [9:0] T_ANN = `BIS_ANN_SEC;
  localparam [9:0] T_TRAN = `BIS_TRANS_SEC;
  localparam [9:0] T_GRACE = `BIS_LF_GRACE_SEC;
  localparam [9:0] T_TRIAL = `BIS_TRIAL_SEC;
  localparam [9:0] T_P2 = `BIS_P2_SEC;
  localparam [9:0] T_STEP = `BIS_STEP_SEC;
  localparam [9:0] T_DEB = `BIS_DEB_SEC;
  // Products are worked out as integers, then cut to the counter widths
  localparam integer ALARM_I = `BIS_ALARM_MIN * `BIS_SEC_PER_MIN;
  localparam integer LOCK_I = `BIS_LOCK_MIN * `BIS_SEC_PER_MIN;
  localparam integer DIV_I = TICK_DIV * `BIS_TICK_PER_SEC - 1;
  localparam [9:0] T_ALARM = ALARM_I[9:0];
  localparam [9:0] T_LOCK = LOCK_I[9:0];
  localparam [23:0] DIV_LAST = DIV_I[23:0];

  // ----------------------------------------------------------------
  // One-second enable
  // ----------------------------------------------------------------
  reg [23:0] divQ;
  reg secTick;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divQ <= 24'h000000;
      secTick <= 1'b0;
    end
    else if (divQ == DIV_LAST)
    begin
      divQ <= 24'h000000;
      secTick <= 1'b1;
    end
    else
    begin
      divQ <= divQ + 24'h000001;
      secTick <= 1'b0;
    end
  end

  reg [11:0] stateQ;
  reg [11:0] stateD;
  reg stepClr;
  reg debClr;
  reg annClr;
  wire [9:0] stepSec;
  wire [9:0] debSec;
  wire [9:0] annSec;

  // Step timer restarts on every state change
  bis_timer #(.WIDTH(10)) uStep (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .secTick(secTick),
    .clear(stepClr),
    .count(stepSec)
  );

  // Debounce of low-fire switch in part three
  bis_timer #(.WIDTH(10)) uDeb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .secTick(secTick),
    .clear(debClr),
    .count(debSec)
  );

  bis_timer #(.WIDTH(10)) uAnn (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .secTick(secTick),
    .clear(annClr),
    .count(annSec)
  );

  // ----------------------------------------------------------------
  // Fault annunciation
  // ----------------------------------------------------------------
  // Waits one tick past the minimum, as the first tick may come at once
  always @*
  begin
    annClr = lineFault;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      faultAnnounce <= 1'b0;
    else if (lineFault)
      faultAnnounce <= 1'b1;
    else if (annSec > T_ANN)
      faultAnnounce <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  wire both24Low = !sf2 && !sf4;
  always @*
  begin
    stateD = stateQ;
    debClr = 1'b1;
    case (stateQ)
      S_INIT:
      begin
        // Step timer is held clear while a line fault persists
        if (!lineFault && stepSec >= T_INIT)
          stateD = S_STBY;
      end
      S_STBY:
      begin
        if (sf1 && !holdActive && limitsOk && lowFireSw)
        begin
          if (seqSelect == `BIS_SEQ_HILO)
            stateD = S_H1;
          else if (seqSelect == `BIS_SEQ_OFFON)
            stateD = S_O1;
          else
            stateD = S_TRAN;
        end
      end
      S_TRAN:
      begin
        if (!limitsOk)
          stateD = S_LOCK;
        else if (stepSec >= T_TRAN)
          stateD = S_N1;
      end
      S_N1:
      begin
        if (!limitsOk)
          stateD = S_LOCK;
        else if (!lowFireSw && stepSec >= T_GRACE)
          stateD = S_LOCK;
        else if (stepSec >= T_TRIAL)
          stateD = flameSensed ? S_N1END : S_LOCK;
      end
      S_N1END:
      begin
        if (!limitsOk || !flameSensed || !lowFireSw)
          stateD = S_LOCK;
        else if (sf2)
          stateD = S_N2;
      end
      S_N2:
      begin
        if (!flameSensed || !lowFireSw)
          stateD = S_LOCK;
        else if (stepSec >= T_P2)
        begin
          if (!sf2)
            stateD = S_N1END;
          else if (sf4)
            stateD = S_N3;
        end
      end
      S_N3:
      begin
        debClr = !(both24Low && lowFireSw);
        if (!limitsOk || !flameSensed || (!sf2 && sf4))
          stateD = S_LOCK;
        else if (both24Low && stepSec >= T_LOCK)
          stateD = S_LOCK;
        else if (both24Low && lowFireSw && debSec >= T_DEB)
          stateD = S_N1END;
        else if (!sf1)
          stateD = S_STBY;
      end
      S_H1:
      begin
        if (stepSec >= T_TRIAL)
          stateD = flameSensed ? S_H2 : S_LOCK;
      end
      S_H2:
      begin
        if (!flameSensed)
          stateD = S_LOCK;
        else if (sf2 && stepSec >= T_STEP)
          stateD = S_HIGH;
      end
      S_HIGH:
      begin
        if (!flameSensed)
          stateD = S_LOCK;
        else if (!sf1)
          stateD = S_STBY;
        else if (!sf2 && stepSec >= T_STEP)
          stateD = S_H2;
      end
      S_O1:
      begin
        if (!limitsOk)
          stateD = S_LOCK;
        else if (stepSec >= T_TRIAL)
          stateD = flameSensed ? S_O2 : S_LOCK;
      end
      S_O2:
      begin
        if (!flameSensed || !limitsOk)
          stateD = S_LOCK;
        else if (!sf1)
          stateD = S_STBY;
      end
      S_LOCK:
      begin
        if (lockoutReset)
          stateD = S_STBY;
      end
      default:
        stateD = S_LOCK;
    endcase
    // Part three time counts since entry; a debounce return to the end of normal one restarts it
    stepClr = (stateD != stateQ) || (stateQ == S_INIT && lineFault);
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      stateQ <= S_INIT;
    else
      stateQ <= stateD;
  end

  // ----------------------------------------------------------------
  // Outputs, registered from the next state
  // ----------------------------------------------------------------
  wire lfAlarm = (stateQ == S_N3) && !lowFireSw && !sf4 &&
    (stepSec >= T_ALARM);
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      igniterOn <= 1'b0;
      pilotOn <= 1'b0;
      mainOn <= 1'b0;
      airOn <= 1'b0;
      flameProven <= 1'b0;
      alarmOn <= 1'b0;
      motorPos <= `BIS_MOTOR_LOW;
      stateCode <= S_INIT;
    end
    else
    begin
      stateCode <= stateD;
      igniterOn <= (stateD == S_N1 && stepSec < T_TRIAL) ||
        stateD == S_H1 || stateD == S_O1;
      pilotOn <= stateD == S_N1 || stateD == S_N1END ||
        stateD == S_N2 || stateD == S_N3 || stateD == S_H1 ||
        stateD == S_H2 || stateD == S_HIGH || stateD == S_O1 ||
        stateD == S_O2;
      mainOn <= stateD == S_N2 || stateD == S_N3 ||
        stateD == S_HIGH || stateD == S_O2;
      airOn <= stateD == S_N2 || stateD == S_N3 ||
        stateD == S_HIGH || stateD == S_O1;
      flameProven <= stateD == S_N1END || stateD == S_N2 ||
        stateD == S_N3 || stateD == S_H2 || stateD == S_HIGH ||
        stateD == S_O2;
      alarmOn <= (stateD == S_LOCK) ||
        (lfAlarm && stateD == S_N3);
      if ((stateD == S_N3 && sf2 && sf4) || stateD == S_HIGH ||
          stateD == S_O1 || stateD == S_O2)
        motorPos <= `BIS_MOTOR_MOD;
      else
        motorPos <= `BIS_MOTOR_LOW;
    end
  end
endmodule // bis_sequencer

// ---- tb/bis_checker.sv ----
// Port assertions for the burner ignition sequencer
`timescale 1ns/10ps
module bis_checker #(
  parameter TICK_DIV = 1
) (
  input wire clk_sys,
  input wire rst_n,
  input wire lineFault,
  input wire holdActive,
  input wire limitsOk,
  input wire flameSensed,
  input wire igniterOn,
  input wire pilotOn,
  input wire mainOn,
  input wire airOn,
  input wire flameProven,
  input wire alarmOn,
  input wire [1:0] motorPos,
  input wire faultAnnounce,
  input wire [11:0] stateCode
);
  localparam int SEC = 10 * TICK_DIV;
  logic [31:0] quietCnt;
  logic [31:0] annCnt;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // ----
  // Healthy-line time in initiate; slack allows a 1 s tick phase
  // ----
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      quietCnt <= '0;
    else if (lineFault || stateCode != 12'h001)
      quietCnt <= '0;
    else
      quietCnt <= quietCnt + 1;
  // Cycles since the line fault went away; saturated means none seen
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      annCnt <= '1;
    else if (lineFault)
      annCnt <= '0;
    else if (annCnt != '1)
      annCnt <= annCnt + 1;
  sequence sInitExit;
    stateCode == 12'h001 ##1 stateCode == 12'h002;
  endsequence
  sequence sLocked;
    stateCode == 12'h000 && alarmOn;
  endsequence
  a_init_dwell: assert property (
    sInitExit |-> $past(quietCnt) >= 9 * SEC - 2)
    else $error("standby too early");
  a_fault_annc: assert property (
    lineFault |=> faultAnnounce) else $error("fault not shown");
  a_hold_stays: assert property (
    stateCode == 12'h002 && holdActive && !lineFault
    |=> stateCode == 12'h002) else $error("left standby on hold");
  a_norm1_out: assert property (
    stateCode == 12'h008 |-> pilotOn && !airOn && !mainOn
    && !flameProven && motorPos == 2'h0) else $error("normal1 outputs");
  a_limits_lock: assert property (
    stateCode == 12'h008 && !limitsOk |=> sLocked)
    else $error("no lockout on limits");
  a_flame_lock: assert property (
    (stateCode == 12'h020 || stateCode == 12'h800) && !flameSensed
    |=> sLocked) else $error("no lockout on flame");
  a_high_out: assert property (
    stateCode == 12'h200 |-> mainOn && airOn && pilotOn && flameProven
    && motorPos == 2'h2) else $error("high outputs");
  a_offon1_out: assert property (
    stateCode == 12'h400 |-> igniterOn && pilotOn && airOn && !mainOn
    && !flameProven && motorPos == 2'h2) else $error("offon1 outputs");
  a_lock_safe: assert property (
    stateCode == 12'h000 |-> alarmOn && !(igniterOn || pilotOn
    || mainOn || airOn || flameProven)) else $error("lockout outputs");
  a_annc_hold: assert property (
    annCnt < 5 * SEC |-> faultAnnounce) else $error("fault shown briefly");
  a_n1end_out: assert property (
    stateCode == 12'h010 |-> flameProven && pilotOn && !igniterOn
    && !mainOn && !airOn) else $error("end of normal1 outputs");
endmodule // bis_checker
bind bis_sequencer bis_checker #(.TICK_DIV(TICK_DIV)) u_chk (
  .clk_sys, .rst_n, .lineFault, .holdActive, .limitsOk, .flameSensed,
  .igniterOn, .pilotOn, .mainOn, .airOn, .flameProven, .alarmOn,
  .motorPos, .faultAnnounce, .stateCode);

// ---- tb/bis_plc_model.sv ----
// Master-control model driving the run inputs as steady levels
`timescale 1ns/10ps
module bis_plc_model (
  input wire clk_sys,
  input wire [5:0] want,
  input wire [1:0] seqSelect,
  output logic limitsOk,
  output logic lowFireSw,
  output logic [3:0] sf
);
  initial {limitsOk, lowFireSw, sf} = '0;
  // ----
  // Levels move just after an edge, then stand
  // ----
  always @(posedge clk_sys)
  begin
    {limitsOk, sf} <= #5 want[4:0];
    // Stepfire runs keep the switch jumpered on
    lowFireSw <= #5 (seqSelect != 2'h0) | want[5];
  end
endmodule // bis_plc_model

// ---- tb/bis_sequencer_tb_top.sv ----
// Self-checking bench for the burner ignition sequencer
`timescale 1ns/10ps
module bis_sequencer_tb_top;
  localparam int SEC = 10;
  logic clk_sys = 0, rst_n = 0, lineFault = 0, holdActive = 0;
  logic flameSensed = 0, lockoutReset = 0;
  logic [1:0] seqSelect = 2'h0, motorPos;
  logic [5:0] want = '0;
  logic limitsOk, lowFireSw, igniterOn, pilotOn, mainOn, airOn;
  logic flameProven, alarmOn, faultAnnounce;
  logic [3:0] sf;
  logic [11:0] stateCode;
  int err_count = 0, tests_run = 0, seed = 32'h21761ceb;
  initial
    forever #50 clk_sys = ~clk_sys;
  bis_plc_model u_plc (.clk_sys, .want, .seqSelect, .limitsOk,
    .lowFireSw, .sf);
  bis_sequencer #(.TICK_DIV(1)) DUT (.clk_sys, .rst_n, .lineFault,
    .seqSelect, .holdActive, .limitsOk, .lowFireSw, .flameSensed,
    .sf1(sf[0]), .sf2(sf[1]), .sf3(sf[2]), .sf4(sf[3]), .lockoutReset,
    .igniterOn, .pilotOn, .mainOn, .airOn, .flameProven, .alarmOn,
    .motorPos, .faultAnnounce, .stateCode);
  // ----
  // Tasks
  // ----
  task automatic final_report;
    if (err_count == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic secs(input int n);
    repeat (n * SEC) @(posedge clk_sys);
    #5;
  endtask
  // Bounded wait; running out ends the run
  task automatic waitSt(input logic [11:0] code, input int lim);
    int i;
    for (i = 0; i < lim * SEC && stateCode !== code; i++)
    begin
      @(posedge clk_sys);
      #5;
    end
    chk(stateCode, code);
    if (stateCode !== code)
      final_report();
  endtask
  // Bits: low fire, limits, sf4, sf3, sf2, sf1; sf3 is noise
  task automatic plc(input logic [5:0] w);
    int r;
    r = $random(seed);
    want = {w[5:3], r[0], w[1:0]};
  endtask
  // Part-three motor command from the two function inputs
  function automatic logic [1:0] expMotor(input logic s2, input logic s4);
    return (s2 && s4) ? 2'h2 : 2'h0;
  endfunction
  task automatic locked(input int lim);
    waitSt(12'h000, lim);
    chk(alarmOn, 1'b1);
    // Drop the run request first, or the reset would restart a sequence
    plc(6'h00);
    secs(1);
    chk(stateCode, 12'h000);
    lockoutReset = 1;
    secs(1);
    lockoutReset = 0;
    waitSt(12'h002, 2);
  endtask
  task automatic run3;
    plc(6'h3b);
    waitSt(12'h040, 16);
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #5;
    rst_n = 1;
    chk(stateCode, 12'h001);
    secs(5);
    lineFault = 1;
    secs(1);
    lineFault = 0;
    secs(4);
    chk(faultAnnounce, 1'b1);
    secs(4);
    chk(stateCode, 12'h001);
    waitSt(12'h002, 4);
    chk(faultAnnounce, 1'b0);
    holdActive = 1;
    flameSensed = 1;
    plc(6'h31);
    secs(3);
    chk(stateCode, 12'h002);
    holdActive = 0;
    waitSt(12'h004, 1);
    waitSt(12'h008, 3);
    waitSt(12'h010, 5);
    secs(1 + ($random(seed) & 3));
    chk(stateCode, 12'h010);
    chk(flameProven, 1'b1);
    plc(6'h33);
    waitSt(12'h020, 1);
    plc(6'h31);
    secs(4);
    chk(stateCode, 12'h020);
    waitSt(12'h010, 2);
    run3();
    chk(motorPos, expMotor(1'b1, 1'b1));
    plc(6'h33);
    secs(1);
    chk(motorPos, expMotor(1'b1, 1'b0));
    plc(6'h31);
    waitSt(12'h010, 4);
    run3();
    plc(6'h11);
    secs(245);
    chk(alarmOn, 1'b1);
    chk(stateCode, 12'h040);
    locked(240);
    run3();
    plc(6'h3a);
    waitSt(12'h002, 1);
    run3();
    plc(6'h39);
    locked(1);
    plc(6'h31);
    waitSt(12'h008, 3);
    plc(6'h21);
    locked(1);
    flameSensed = 0;
    plc(6'h31);
    locked(10);
    seqSelect = 2'h1;
    flameSensed = 1;
    plc(6'h11);
    waitSt(12'h080, 1);
    waitSt(12'h100, 5);
    plc(6'h13);
    waitSt(12'h200, 3);
    plc(6'h11);
    secs(1);
    chk(stateCode, 12'h200);
    waitSt(12'h100, 2);
    plc(6'h13);
    waitSt(12'h200, 3);
    plc(6'h12);
    waitSt(12'h002, 1);
    seqSelect = 2'h2;
    flameSensed = 0;
    plc(6'h11);
    waitSt(12'h400, 1);
    secs(2);
    chk(stateCode, 12'h400);
    flameSensed = 1;
    waitSt(12'h800, 3);
    flameSensed = 0;
    locked(1);
    final_report();
  end
endmodule // bis_sequencer_tb_top
